// ==== pkg/acp_pkg.sv ====
// constants and types for the serial conversion port
package acp_pkg;
	// ==========================================================
	// word layout
	localparam int RESULT_BITS = 8;
	localparam int MUX_BITS    = 2;
	localparam int DUMMY_BITS  = 2;
	localparam int NULL_BITS   = 2;
	localparam int EDGE_BITS   = 4;

	// ==========================================================
	// timing, counted in shift-clock half cycles
	localparam int SAMPLE_HALF_CYCLES = 5;
	localparam int CONV_HALF_CYCLES   = 17;

	// ==========================================================
	// rising-edge numbers after the start bit (start bit is edge 0)
	localparam logic [3:0] EDGE_WINDOW_OPEN  = 4'h2;
	localparam logic [3:0] EDGE_HOLD         = 4'h4;
	localparam logic [3:0] EDGE_FIRST_RESULT = 4'h6;
	localparam logic [3:0] EDGE_LAST_RESULT  = 4'hD;

	// ==========================================================
	// straight-binary code points and reset values
	localparam logic [7:0] CODE_ZERO    = 8'h00;
	localparam logic [7:0] CODE_ONE_LSB = 8'h01;
	localparam logic [7:0] CODE_FULL    = 8'hFF;
	localparam logic [7:0] SAR_FIRST_MASK = 8'h80;
	localparam logic [1:0] MUX_RESET    = 2'h0;
	// idle pin levels {sdi, sclk, cs_n}: deselected, clock low
	localparam logic [2:0] PIN_IDLE     = 3'h1;

	// ==========================================================
	// transfer sequencer
	typedef enum logic [1:0] {
		ACP_WAIT = 2'b00,
		ACP_WORD = 2'b01,
		ACP_XFER = 2'b11,
		ACP_TAIL = 2'b10
	} acp_state_e;
endpackage

// ==== design/acp_sync.sv ====
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module acp_sync #(
	parameter int               WIDTH     = 3,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             sys_clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] sync;
	logic [WIDTH-1:0] prev;

	// ==========================================================
	// registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= RESET_VAL;
			sync <= RESET_VAL;
			prev <= RESET_VAL;
		end else begin
			meta <= async_in;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level = sync;
	assign rise  = sync & ~prev;
	assign fall  = ~sync & prev;
endmodule
`default_nettype wire

// ==== design/acp_sar.sv ====
// successive-approximation register
`timescale 1ns/1ps
`default_nettype none
module acp_sar #(
	parameter int BITS = acp_pkg::RESULT_BITS
) (
	input  wire logic            sys_clk,
	input  wire logic            arst_n,
	input  wire logic            clear,
	input  wire logic            start,
	input  wire logic            step,
	input  wire logic            comp_hi,
	output logic      [BITS-1:0] trial,
	output logic      [BITS-1:0] code
);
	logic [BITS-1:0] mask;
	logic [BITS-1:0] next_mask;
	logic [BITS-1:0] next_code;

	// ==========================================================
	// next bit decision
	always_comb begin
		next_mask = mask;
		next_code = code;
		if (clear) begin
			next_mask = '0;
			next_code = '0;
		end else if (start) begin
			next_mask = BITS'(acp_pkg::SAR_FIRST_MASK);
			next_code = '0;
		end else if (step) begin
			if (comp_hi) begin
				next_code = code | mask;
			end
			next_mask = mask >> 1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mask <= '0;
			code <= '0;
		end else begin
			mask <= next_mask;
			code <= next_code;
		end
	end

	assign trial = code | mask;
endmodule
`default_nettype wire

// ==== design/acp_port.sv ====
// serial conversion port: input word, sampling, conversion, result shift
//
// Functional notes
// - dummy bits accepted at either value
// - dummies give two and half clocks acquisition
// - two null bits precede the result
// - output bit changes only on rising edges
// - result is unipolar straight binary code
// - shared wire driven low on fifth fall
// - powered only while chip select low
// - clock and input ignored while deselected
// - window opens before dummies, closes after
// - window end switches to hold, converts
// - conversion lasts eight and half clocks
// - leading zeros skipped, later input ignored
// - two bits after start select channel
// - result msb first, then zeros forever
// - input bits taken on rising edge
`timescale 1ns/1ps
`default_nettype none
module acp_port (
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic       cs_n_pin,
	input  wire logic       sclk_pin,
	input  wire logic       sdi_pin,
	input  wire logic       comp_hi,
	output logic            sdo,
	output logic            sdo_oe,
	output logic            power_en,
	output logic            sample_window,
	output logic            hold,
	output logic [1:0]      mux_sel,
	output logic [7:0]      dac_trial,
	output logic [7:0]      result_code,
	output logic            result_valid
);
	logic [2:0]              pin_level;
	logic [2:0]              pin_rise;
	logic [2:0]              pin_fall;
	logic                    cs_hi;
	logic                    sclk_rise;
	logic                    sclk_fall;
	logic                    sdi;
	acp_pkg::acp_state_e     state;
	acp_pkg::acp_state_e     next_state;
	logic [3:0]              rcnt;
	logic [3:0]              next_rcnt;
	logic [3:0]              rnext;
	logic [3:0]              bit_idx;
	logic [1:0]              next_mux_sel;
	logic                    next_sdo;
	logic                    next_sdo_oe;
	logic                    next_window;
	logic                    next_hold;
	logic                    next_valid;
	logic                    next_power;
	logic [7:0]              next_result;
	logic                    sar_start;
	logic                    sar_step;
	logic [7:0]              sar_code;
	logic [3:0]              win_halves;
	logic [3:0]              next_win_halves;
	logic [4:0]              hold_halves;
	logic [4:0]              next_hold_halves;

	// ==========================================================
	// pin synchronisers
	acp_sync #(
		.WIDTH     (3),
		.RESET_VAL (acp_pkg::PIN_IDLE)
	) u_sync (
		.sys_clk  (sys_clk),
		.arst_n   (arst_n),
		.async_in ({sdi_pin, sclk_pin, cs_n_pin}),
		.level    (pin_level),
		.rise     (pin_rise),
		.fall     (pin_fall)
	);

	assign cs_hi     = pin_level[0];
	assign sclk_rise = pin_rise[1];
	assign sclk_fall = pin_fall[1];
	assign sdi       = pin_level[2];

	// ==========================================================
	// converter
	acp_sar #(
		.BITS(acp_pkg::RESULT_BITS)
	) u_sar (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.clear   (cs_hi),
		.start   (sar_start),
		.step    (sar_step),
		.comp_hi (comp_hi),
		.trial   (dac_trial),
		.code    (sar_code)
	);

	// ==========================================================
	// transfer sequencer
	always_comb begin
		next_state   = state;
		next_rcnt    = rcnt;
		next_mux_sel = mux_sel;
		next_sdo     = sdo;
		next_sdo_oe  = sdo_oe;
		next_window  = sample_window;
		next_hold    = hold;
		next_valid   = 1'b0;
		next_result  = result_code;
		next_power   = !cs_hi;
		sar_start    = 1'b0;
		sar_step     = 1'b0;
		rnext        = rcnt + 4'h1;
		bit_idx      = acp_pkg::EDGE_LAST_RESULT - rnext;
		if (cs_hi) begin
			next_state  = acp_pkg::ACP_WAIT;
			next_rcnt   = 4'h0;
			next_sdo    = 1'b0;
			next_sdo_oe = 1'b0;
			next_window = 1'b0;
			next_hold   = 1'b0;
		end else begin
			case (state)
				acp_pkg::ACP_WAIT: begin
					if (sclk_rise && sdi) begin
						next_state = acp_pkg::ACP_WORD;
						next_rcnt  = 4'h0;
					end
				end
				acp_pkg::ACP_WORD: begin
					if (sclk_rise) begin
						next_rcnt = rnext;
						if (rnext <= 4'(acp_pkg::MUX_BITS)) begin
							next_mux_sel = {mux_sel[0], sdi};
						end
						if (rnext == acp_pkg::EDGE_WINDOW_OPEN) begin
							next_window = 1'b1;
						end
						if (rnext == acp_pkg::EDGE_HOLD) begin
							next_state = acp_pkg::ACP_XFER;
						end
					end
				end
				acp_pkg::ACP_XFER: begin
					if (sclk_fall && rcnt == acp_pkg::EDGE_HOLD) begin
						next_window = 1'b0;
						next_hold   = 1'b1;
						sar_start   = 1'b1;
						next_sdo_oe = 1'b1;
						next_sdo    = 1'b0;
					end else if (sclk_fall && rcnt > acp_pkg::EDGE_HOLD
							&& rcnt < acp_pkg::EDGE_LAST_RESULT) begin
						sar_step = 1'b1;
					end
					if (sclk_rise) begin
						next_rcnt = rnext;
						if (rnext < acp_pkg::EDGE_FIRST_RESULT) begin
							next_sdo = 1'b0;
						end else begin
							next_sdo = sar_code[bit_idx[2:0]];
						end
						if (rnext == acp_pkg::EDGE_LAST_RESULT) begin
							next_state  = acp_pkg::ACP_TAIL;
							next_hold   = 1'b0;
							next_valid  = 1'b1;
							next_result = sar_code;
						end
					end
				end
				acp_pkg::ACP_TAIL: begin
					if (sclk_rise) begin
						next_sdo = 1'b0;
					end
				end
				default: begin
					next_state = acp_pkg::ACP_WAIT;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state         <= acp_pkg::ACP_WAIT;
			rcnt          <= 4'h0;
			mux_sel       <= acp_pkg::MUX_RESET;
			sdo           <= 1'b0;
			sdo_oe        <= 1'b0;
			sample_window <= 1'b0;
			hold          <= 1'b0;
			result_valid  <= 1'b0;
			result_code   <= acp_pkg::CODE_ZERO;
			power_en      <= 1'b0;
		end else begin
			state         <= next_state;
			rcnt          <= next_rcnt;
			mux_sel       <= next_mux_sel;
			sdo           <= next_sdo;
			sdo_oe        <= next_sdo_oe;
			sample_window <= next_window;
			hold          <= next_hold;
			result_valid  <= next_valid;
			result_code   <= next_result;
			power_en      <= next_power;
		end
	end

	// ==========================================================
	// shift-clock half cycles spent sampling and converting
	always_comb begin
		next_win_halves  = '0;
		next_hold_halves = '0;
		if (sample_window) begin
			next_win_halves = win_halves + {3'h0, sclk_rise | sclk_fall};
		end
		if (hold) begin
			next_hold_halves = hold_halves + {4'h0, sclk_rise | sclk_fall};
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			win_halves  <= '0;
			hold_halves <= '0;
		end else begin
			win_halves  <= next_win_halves;
			hold_halves <= next_hold_halves;
		end
	end

	// ==========================================================
	// checks
	AST_FLOAT_WHEN_DESELECTED: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		cs_hi |=> (!sdo_oe && state == acp_pkg::ACP_WAIT))
		else $error("output driven or sequencer armed while deselected");

	AST_SDO_ON_RISE: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		$changed(sdo) |-> ($past(sclk_rise) || $past(cs_hi)))
		else $error("serial output changed without a rising edge");

	AST_DRIVE_ON_FALL: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		$rose(sdo_oe) |-> ($past(sclk_fall) && !sdo && hold
			&& rcnt == acp_pkg::EDGE_HOLD))
		else $error("shared wire taken at the wrong edge or not low");

	AST_NULL_BIT: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(state == acp_pkg::ACP_XFER && sclk_rise && !cs_hi
			&& rcnt == acp_pkg::EDGE_HOLD) |=> !sdo)
		else $error("second null bit not zero");

	AST_WINDOW_TO_HOLD: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		($fell(sample_window) && !$past(cs_hi)) |-> (hold && $past(sclk_fall)))
		else $error("window closed without entering hold");

	AST_POWER_FOLLOWS_CS: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		cs_hi |=> !power_en)
		else $error("powered while deselected");

	AST_TAIL_ZEROS: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(state == acp_pkg::ACP_TAIL && sclk_rise && !cs_hi) |=> !sdo)
		else $error("nonzero bit after the result");

	AST_MUX_CAPTURE: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(state == acp_pkg::ACP_WORD && sclk_rise && !cs_hi && rcnt == 4'h1)
			|=> (mux_sel[0] == $past(sdi)))
		else $error("channel bit not captured");

	AST_VALID_WITH_RESULT: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		result_valid |-> ($past(rcnt) == 4'hC && state == acp_pkg::ACP_TAIL
			&& !hold && sdo == result_code[0]))
		else $error("conversion ended at the wrong edge");

	AST_WINDOW_OPENS: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		$rose(sample_window) |-> ($past(sclk_rise) && state == acp_pkg::ACP_WORD
			&& rcnt == acp_pkg::EDGE_WINDOW_OPEN))
		else $error("sampling window opened at the wrong edge");

	AST_WINDOW_LENGTH: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		($fell(sample_window) && !$past(cs_hi))
			|-> (win_halves == 4'(acp_pkg::SAMPLE_HALF_CYCLES)))
		else $error("sampling window not two and a half clocks long");

	AST_CONVERSION_LENGTH: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		($fell(hold) && !$past(cs_hi))
			|-> (hold_halves == 5'(acp_pkg::CONV_HALF_CYCLES)))
		else $error("conversion not eight and a half clocks long");

	AST_SKIP_ZEROS: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(state == acp_pkg::ACP_WAIT && !cs_hi && !(sclk_rise && sdi))
			|=> (state == acp_pkg::ACP_WAIT))
		else $error("start taken without a one on a rising edge");

	AST_START_BIT: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(state == acp_pkg::ACP_WAIT && !cs_hi && sclk_rise && sdi)
			|=> (state == acp_pkg::ACP_WORD && rcnt == 4'h0))
		else $error("start bit not taken");

	AST_IGNORE_DESELECTED: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		cs_hi |=> ($stable(mux_sel) && !sample_window && !hold && !result_valid))
		else $error("deselected port reacted to its inputs");
endmodule
`default_nettype wire

// ==== dv/acp_host.sv ====
// host-side model: chip select, shift clock and the shared data wire
`timescale 1ns/1ps
`default_nettype none
module acp_host (
	output logic        cs_n,
	output logic        sclk,
	output logic        host_d,
	output logic        host_oe,
	input  wire logic   dq,
	output logic [12:0] rx,
	output logic        rx_done
);
	// ==========================================================
	// 8 MHz shift clock
	localparam real HALF = 62.5;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		host_d = 1'b0;
		host_oe = 1'b0;
		rx = '0;
		rx_done = 1'b0;
	end
	// ==========================================================
	// one rising edge, optional capture of the wire
	task automatic rise(input bit cap);
		#HALF sclk = 1'b1;
		if (cap) rx = {rx[11:0], dq};
		#HALF sclk = 1'b0;
	endtask
	task automatic send(input logic b);
		host_d = b;
		host_oe = 1'b1;
		rise(1'b0);
	endtask
	// ==========================================================
	// toggling while deselected
	task automatic noise(input logic [7:0] pat);
		for (int i = 0; i < 8; i++) send(pat[i]);
		host_oe = 1'b0;
	endtask
	// ==========================================================
	// one transfer, optionally cut short after the channel bits
	task automatic frame(input int lz, input logic [1:0] mux, input logic [1:0] dum,
			input bit abort);
		cs_n = 1'b0;
		#100;
		repeat (lz) send(1'b0);
		send(1'b1);
		send(mux[1]);
		send(mux[0]);
		if (!abort) begin
			send(dum[1]);
			host_d = dum[0];
			#HALF sclk = 1'b1;
			#20 host_oe = 1'b0;
			#30 rx = {12'h000, dq};
			#(HALF - 50.0) sclk = 1'b0;
			repeat (12) rise(1'b1);
			rx_done = 1'b1;
			#10 rx_done = 1'b0;
		end
		host_oe = 1'b0;
		#HALF cs_n = 1'b1;
		#100;
	endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// testbench of the serial conversion port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_errors++; \
	$display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
	logic        sys_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  vin = 8'h00;
	logic        cs_n, sclk, host_d, host_oe, rx_done;
	logic [12:0] rx;
	logic        sdo, sdo_oe, power_en, sample_window, hold, result_valid;
	logic [1:0]  mux_sel;
	logic [7:0]  dac_trial, result_code;
	wire logic   dq;
	wire logic   comp_hi;
	int          n_errors = 0;
	int          comparisons = 0;
	integer      seed;
	logic [9:0]  q_par[$];
	logic [12:0] q_ser[$];
	logic [12:0] exp_ser;

	always #5 sys_clk = ~sys_clk;
	// shared wire with pull-up, comparator model
	assign dq = sdo_oe ? sdo : (host_oe ? host_d : 1'b1);
	assign comp_hi = (vin >= dac_trial);

	acp_port uut (.sys_clk(sys_clk), .arst_n(arst_n), .cs_n_pin(cs_n), .sclk_pin(sclk),
		.sdi_pin(dq), .comp_hi(comp_hi), .sdo(sdo), .sdo_oe(sdo_oe), .power_en(power_en),
		.sample_window(sample_window), .hold(hold), .mux_sel(mux_sel),
		.dac_trial(dac_trial), .result_code(result_code), .result_valid(result_valid));
	acp_host host (.cs_n(cs_n), .sclk(sclk), .host_d(host_d), .host_oe(host_oe), .dq(dq),
		.rx(rx), .rx_done(rx_done));

	task automatic give_verdict();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// watchers
	always @(posedge sys_clk) begin
		`CHK("contention", 1'b0, sdo_oe & host_oe)
		if (result_valid === 1'b1) begin
			if (q_par.size() == 0) `CHK("spurious result", 1'b0, 1'b1)
			else begin
				`CHK("result_code", q_par[0][7:0], result_code)
				`CHK("mux_sel", q_par[0][9:8], mux_sel)
				`CHK("power_en", 1'b1, power_en)
				void'(q_par.pop_front());
			end
		end
	end
	always @(posedge rx_done) begin
		if (q_ser.size() == 0) `CHK("spurious word", 1'b0, 1'b1)
		else begin
			exp_ser = q_ser.pop_front();
			`CHK("serial word", exp_ser, rx)
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		logic [7:0]  tbl[5];
		logic [7:0]  v;
		logic [31:0] r;
		tbl = '{8'h00, 8'h01, 8'hFF, 8'h80, 8'h7F};
		seed = 87;
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk) arst_n = 1'b1;
		repeat (5) @(negedge sys_clk);
		host.noise(8'hA5);
		repeat (5) @(negedge sys_clk);
		`CHK("idle outputs", 4'h0, {power_en, sdo_oe, sample_window, hold})
		host.frame(1, 2'h3, 2'h0, 1'b1);
		`CHK("deselect outputs", 3'h0, {sdo_oe, sample_window, power_en})
		for (int i = 0; i < 12; i++) begin
			r = $random(seed);
			v = (i < 5) ? tbl[i] : r[15:8];
			@(negedge sys_clk) vin = v;
			q_par.push_back({2'(i), v});
			q_ser.push_back({1'b1, 2'b00, v, 2'b00});
			host.frame(int'(r[5:4]), 2'(i), r[1:0], 1'b0);
		end
		for (int k = 0; k < 200 && (q_par.size() + q_ser.size()) != 0; k++)
			@(posedge sys_clk);
		`CHK("pending results", 0, q_par.size() + q_ser.size())
		give_verdict();
	end
	initial begin
		#300000;
		n_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
